/* vdoc_meas_model.sv */
// Measurement front end and user logic model feeding the protection inputs
`timescale 1ns/1ps
module vdoc_meas_model
	import vdoc_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic [15:0] cur_cmd_i [3],
	input  wire logic [15:0] volt_cmd_i [3],
	input  wire logic        ublk_cmd_i,
	input  wire logic        vtblk_cmd_i,
	output logic      [15:0] cur_o [3],
	output logic      [15:0] volt_o [3],
	output logic      [15:0] line_o [3],
	output logic             ublk_o,
	output logic             vtblk_o
);
	// Outputs are unknown until the first edge; the bench holds reset well past it
	// fundamental magnitudes and derived line voltages
	// Line value is the mean of its two phases: crude, but it stays in percent of nominal
	// two separate blocking sources
	always @(posedge clk_i) begin
		for (int i = 0; i < 3; i++) begin
			cur_o[i]  <= cur_cmd_i[i];
			volt_o[i] <= volt_cmd_i[i];
			line_o[i] <= 16'((17'(volt_cmd_i[i]) + 17'(volt_cmd_i[(i + 1) % 3])) >> 1);
		end
		ublk_o  <= ublk_cmd_i;
		vtblk_o <= vtblk_cmd_i;
	end
endmodule : vdoc_meas_model

/* vdoc_phase.sv */
// One phase: voltage dependent threshold and definite time delay
`timescale 1ns/1ps
module vdoc_phase
	import vdoc_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        enable_i,
	input  vdoc_mode_t       mode_i,
	input  wire logic [15:0] cur_i,
	input  wire logic [15:0] volt_i,
	input  wire logic [6:0]  u_low_i,
	input  wire logic [6:0]  u_high_i,
	input  wire logic [6:0]  ik_i,
	input  wire logic [11:0] pickup_i,
	input  wire logic [15:0] delay_ms_i,
	input  wire logic        blocked_i,
	input  wire logic        ms_tick_i,
	output logic             operate_o,
	output logic             start_o,
	output logic             trip_o
);

	logic [6:0]  ik_eff;
	logic [6:0]  span;
	logic [15:0] above;
	logic [39:0] lhs;
	logic [39:0] rhs;
	logic [15:0] cnt;

	// A factor above full scale would bend the line downward
	assign ik_eff = (ik_i > PCT_SCALE) ? PCT_SCALE : ik_i;
	assign span   = (u_high_i > u_low_i) ? 7'(u_high_i - u_low_i) : 7'h00;
	assign above  = 16'(volt_i - {9'h000, u_low_i});

	// R6 straight line, cross multiplied to avoid a divider
	assign lhs = 40'(cur_i) * 40'(PCT_SCALE) * 40'(span);
	assign rhs = 40'(pickup_i) * 40'(ik_eff) * 40'(span)
		+ 40'(pickup_i) * 40'(7'(PCT_SCALE - ik_eff)) * 40'(above);

	// Operate region of the current voltage/current point
	always_comb begin
		operate_o = 1'b0;
		if (enable_i) begin
			if (mode_i == VDOC_CONTROLLED) begin
				// R7 constant threshold, low voltage only
				operate_o = (volt_i < 16'(u_low_i)) && (cur_i > 16'(pickup_i));
			end else if (volt_i >= 16'(u_high_i)) begin
				// R4 full pickup above upper knee
				operate_o = cur_i > 16'(pickup_i);
			end else if (volt_i <= 16'(u_low_i) || span == 7'h00) begin
				// R5 reduced threshold below lower knee
				operate_o = 40'(cur_i) * 40'(PCT_SCALE) > 40'(pickup_i) * 40'(ik_eff);
			end else begin
				// R6 interpolated threshold
				operate_o = lhs > rhs;
			end
		end
	end

	// R8 definite time delay, R14 cleared on leaving or block
	always_ff @(posedge clk_i) begin
		if (rst_i || !operate_o || blocked_i) begin
			cnt     <= 16'h0000;
			start_o <= 1'b0;
			trip_o  <= 1'b0;
		end else begin
			start_o <= 1'b1;
			if (ms_tick_i && cnt < delay_ms_i)
				cnt <= cnt + 16'h0001;
			trip_o <= cnt >= delay_ms_i;
		end
	end

endmodule : vdoc_phase

/* vdoc_pkg.sv */
// Shared constants and types of the voltage dependent overcurrent block
package vdoc_pkg;

	// Clock and millisecond tick
	localparam int CLK_PERIOD_NS = 10;
	localparam int MS_NS         = 1000000;
	localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;

	// Percentage scale of the reduced threshold
	localparam logic [6:0] PCT_SCALE = 7'h64;

	// Register byte offsets
	localparam logic [7:0] REG_CTRL       = 8'h00;
	localparam logic [7:0] REG_U_LOW      = 8'h04;
	localparam logic [7:0] REG_U_HIGH     = 8'h08;
	localparam logic [7:0] REG_IK_FACTOR  = 8'h0c;
	localparam logic [7:0] REG_PICKUP     = 8'h10;
	localparam logic [7:0] REG_DELAY      = 8'h14;
	localparam logic [7:0] REG_STATUS     = 8'h18;
	localparam logic [7:0] REG_IRQ_STATUS = 8'h1c;
	localparam logic [7:0] REG_IRQ_MASK   = 8'h20;

	// Control fields
	localparam int CTRL_EN_BIT   = 0;
	localparam int CTRL_MODE_BIT = 1;
	localparam int CTRL_LL_BIT   = 2;

	// Live status fields
	localparam int ST_START_LSB  = 0;
	localparam int ST_TRIP_LSB   = 3;
	localparam int ST_GSTART_BIT = 6;
	localparam int ST_GTRIP_BIT  = 7;

	// Interrupt status fields
	localparam int IRQ_START_LSB  = 0;
	localparam int IRQ_GSTART_BIT = 3;
	localparam int IRQ_GTRIP_BIT  = 4;
	localparam int IRQ_W          = 5;

	// Reset values
	localparam logic [2:0]  RST_CTRL   = 3'h0;
	localparam logic [6:0]  RST_U_LOW  = 7'h1e;
	localparam logic [6:0]  RST_U_HIGH = 7'h50;
	localparam logic [6:0]  RST_IK     = 7'h1e;
	localparam logic [11:0] RST_PICKUP = 12'h0c8;
	localparam logic [15:0] RST_DELAY  = 16'h0064;

	// Characteristic selection
	typedef enum logic {
		VDOC_RESTRAINED,
		VDOC_CONTROLLED
	} vdoc_mode_t;

endpackage : vdoc_pkg

/* vdoc_top.sv */
// Voltage dependent overcurrent protection with Wishbone registers
// Summary of operation
// R1 - Restrained or controlled characteristic chosen by the mode setting.
// R2 - Threshold from fundamental voltages; fundamental currents compared against it.
// R3 - Voltage inputs are phase voltages or line-to-line voltages.
// R4 - Restrained, above upper knee: operate while current exceeds pickup.
// R5 - Restrained, below lower knee: threshold is pickup times factor over 100.
// R6 - Restrained, between knees: threshold interpolated along a straight line.
// R7 - Controlled: pickup threshold, operate only below lower knee.
// R8 - Operate region runs the definite time delay before a phase trips.
// R9 - Per-phase decisions; general start and trip are their OR.
// R10 - General trip when a phase exceeds threshold and its delay expired.
// R11 - User block or VT supervision block suppresses all starts and trips.
// R12 - Separate start outputs for phases one, two and three.
// R13 - Outside logic supplies a separate VT supervision block input.
// R14 - Phase timer and start clear on leaving region or blocking.
// R15 - General trip holds while a phase stays operated and expired.
//
// Our own choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
module vdoc_top
	import vdoc_pkg::*;
#(
	parameter int TICK_CYCLES = MS_CYCLES
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic [15:0] phase1_cur_i,
	input  wire logic [15:0] phase2_cur_i,
	input  wire logic [15:0] phase3_cur_i,
	input  wire logic [15:0] phase1_volt_i,
	input  wire logic [15:0] phase2_volt_i,
	input  wire logic [15:0] phase3_volt_i,
	input  wire logic [15:0] line12_volt_i,
	input  wire logic [15:0] line23_volt_i,
	input  wire logic [15:0] line31_volt_i,
	input  wire logic        user_block_in_i,
	input  wire logic        vt_supervision_block_in_i,
	output logic             phase1_start_out_o,
	output logic             phase2_start_out_o,
	output logic             phase3_start_out_o,
	output logic             general_start_out_o,
	output logic             general_trip_out_o,
	output logic             irq_o
);

	logic [2:0]         ctrl;
	logic [6:0]         u_low;
	logic [6:0]         u_high;
	logic [6:0]         ik_factor;
	logic [11:0]        pickup;
	logic [15:0]        delay_ms;
	logic [IRQ_W-1:0]   irq_status;
	logic [IRQ_W-1:0]   irq_mask;
	logic [IRQ_W-1:0]   irq_event;
	logic [IRQ_W-1:0]   irq_w1c;
	logic [15:0]        cur   [3];
	logic [15:0]        volt  [3];
	logic [2:0]         ph_operate;
	logic [2:0]         ph_start;
	logic [2:0]         ph_trip;
	logic [2:0]         start_q;
	logic [2:0]         trip_q;
	logic [2:0]         start_prev;
	logic               gstart_prev;
	logic               gtrip_prev;
	logic               blocked;
	logic               ms_tick;
	logic [16:0]        tick_cnt;
	logic               bus_req;
	logic               bus_wr;
	logic [7:0]         offs;
	logic [31:0]        next_rdata;
	vdoc_mode_t         mode;

	// Byte lane merge of a write into a register image
	function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] sel);
		logic [31:0] res;
		res = old_v;
		for (int b = 0; b < 4; b++) begin
			if (sel[b])
				res[8*b +: 8] = new_v[8*b +: 8];
		end
		return res;
	endfunction : merge

	// Request decode; a new request is taken only while ack is low
	assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign bus_wr  = bus_req && wb_we_i;
	assign offs    = {wb_adr_i[7:2], 2'b00};
	assign mode    = ctrl[CTRL_MODE_BIT] ? VDOC_CONTROLLED : VDOC_RESTRAINED;

	// R11 either blocking input suppresses the function
	// R13 VT supervision has its own input
	assign blocked = user_block_in_i || vt_supervision_block_in_i;

	// R2 fundamental magnitudes, R3 phase or line-to-line voltages
	assign cur[0]  = phase1_cur_i;
	assign cur[1]  = phase2_cur_i;
	assign cur[2]  = phase3_cur_i;
	assign volt[0] = ctrl[CTRL_LL_BIT] ? line12_volt_i : phase1_volt_i;
	assign volt[1] = ctrl[CTRL_LL_BIT] ? line23_volt_i : phase2_volt_i;
	assign volt[2] = ctrl[CTRL_LL_BIT] ? line31_volt_i : phase3_volt_i;

	// Millisecond tick shared by the three delay timers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tick_cnt <= 17'h00000;
			ms_tick  <= 1'b0;
		end else if (tick_cnt == 17'(TICK_CYCLES - 1)) begin
			tick_cnt <= 17'h00000;
			ms_tick  <= 1'b1;
		end else begin
			tick_cnt <= tick_cnt + 17'h00001;
			ms_tick  <= 1'b0;
		end
	end

	// R1 mode steers each phase, R9 separate phase decisions
	for (genvar p = 0; p < 3; p++) begin : g_phase
		vdoc_phase u_phase (
			.clk_i      (clk_i),
			.rst_i      (rst_i),
			.enable_i   (ctrl[CTRL_EN_BIT]),
			.mode_i     (mode),
			.cur_i      (cur[p]),
			.volt_i     (volt[p]),
			.u_low_i    (u_low),
			.u_high_i   (u_high),
			.ik_i       (ik_factor),
			.pickup_i   (pickup),
			.delay_ms_i (delay_ms),
			.blocked_i  (blocked),
			.ms_tick_i  (ms_tick),
			.operate_o  (ph_operate[p]),
			.start_o    (ph_start[p]),
			.trip_o     (ph_trip[p])
		);
	end

	// R12 phase starts, R9 general OR, R11 gated by block
	always_ff @(posedge clk_i) begin
		if (rst_i || blocked) begin
			start_q             <= 3'h0;
			trip_q              <= 3'h0;
			general_start_out_o <= 1'b0;
			general_trip_out_o  <= 1'b0;
		end else begin
			start_q             <= ph_start;
			trip_q              <= ph_trip;
			general_start_out_o <= |ph_start;
			// R10 trip once a phase delay expired, R15 held while it lasts
			general_trip_out_o  <= |ph_trip;
		end
	end

	assign phase1_start_out_o = start_q[0];
	assign phase2_start_out_o = start_q[1];
	assign phase3_start_out_o = start_q[2];

	// Rising edges of the outputs are the interrupt events
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			start_prev  <= 3'h0;
			gstart_prev <= 1'b0;
			gtrip_prev  <= 1'b0;
		end else begin
			start_prev  <= start_q;
			gstart_prev <= general_start_out_o;
			gtrip_prev  <= general_trip_out_o;
		end
	end

	assign irq_event[IRQ_START_LSB +: 3] = start_q & ~start_prev;
	assign irq_event[IRQ_GSTART_BIT]     = general_start_out_o && !gstart_prev;
	assign irq_event[IRQ_GTRIP_BIT]      = general_trip_out_o && !gtrip_prev;
	assign irq_w1c = (bus_wr && offs == REG_IRQ_STATUS && wb_sel_i[0]) ? wb_dat_i[IRQ_W-1:0]
		: '0;

	// Sticky status; an event in the clearing cycle survives
	always_ff @(posedge clk_i) begin
		if (rst_i)
			irq_status <= '0;
		else
			irq_status <= (irq_status & ~irq_w1c) | irq_event;
	end

	// Level interrupt from unmasked sticky bits
	always_ff @(posedge clk_i) begin
		if (rst_i)
			irq_o <= 1'b0;
		else
			irq_o <= |(((irq_status & ~irq_w1c) | irq_event) & irq_mask);
	end

	// Settings registers written with byte enables
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl      <= RST_CTRL;
			u_low     <= RST_U_LOW;
			u_high    <= RST_U_HIGH;
			ik_factor <= RST_IK;
			pickup    <= RST_PICKUP;
			delay_ms  <= RST_DELAY;
			irq_mask  <= '0;
		end else if (bus_wr) begin
			unique case (offs)
				REG_CTRL:      ctrl      <= 3'(merge(32'(ctrl), wb_dat_i, wb_sel_i));
				REG_U_LOW:     u_low     <= 7'(merge(32'(u_low), wb_dat_i, wb_sel_i));
				REG_U_HIGH:    u_high    <= 7'(merge(32'(u_high), wb_dat_i, wb_sel_i));
				REG_IK_FACTOR: ik_factor <= 7'(merge(32'(ik_factor), wb_dat_i, wb_sel_i));
				REG_PICKUP:    pickup    <= 12'(merge(32'(pickup), wb_dat_i, wb_sel_i));
				REG_DELAY:     delay_ms  <= 16'(merge(32'(delay_ms), wb_dat_i, wb_sel_i));
				REG_IRQ_MASK:  irq_mask  <= IRQ_W'(merge(32'(irq_mask), wb_dat_i, wb_sel_i));
				default: ;
			endcase
		end
	end

	// Read mux; unmapped offsets read zero
	always_comb begin
		next_rdata = 32'h0000_0000;
		unique case (offs)
			REG_CTRL:       next_rdata = 32'(ctrl);
			REG_U_LOW:      next_rdata = 32'(u_low);
			REG_U_HIGH:     next_rdata = 32'(u_high);
			REG_IK_FACTOR:  next_rdata = 32'(ik_factor);
			REG_PICKUP:     next_rdata = 32'(pickup);
			REG_DELAY:      next_rdata = 32'(delay_ms);
			REG_STATUS: begin
				next_rdata[ST_START_LSB +: 3] = start_q;
				next_rdata[ST_TRIP_LSB +: 3]  = trip_q;
				next_rdata[ST_GSTART_BIT]     = general_start_out_o;
				next_rdata[ST_GTRIP_BIT]      = general_trip_out_o;
			end
			REG_IRQ_STATUS: next_rdata = 32'(irq_status);
			REG_IRQ_MASK:   next_rdata = 32'(irq_mask);
			default:        next_rdata = 32'h0000_0000;
		endcase
	end

	// One wait state: ack the cycle after the strobe, every offset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= bus_req;
			if (bus_req && !wb_we_i)
				wb_dat_o <= next_rdata;
		end
	end

	// Helper: ms ticks seen while phase one sits unblocked in its operate region
	logic [15:0] chk_ticks;
	always_ff @(posedge clk_i) begin
		if (rst_i || !ph_operate[0] || blocked)
			chk_ticks <= 16'h0000;
		else if (ms_tick && chk_ticks != 16'hffff)
			chk_ticks <= chk_ticks + 16'h0001;
	end

	// Blocking empties the general start and trip one edge on and the phase starts by the edge after
	property p_block_clears;
		@(posedge clk_i) disable iff (rst_i)
		blocked |=> !general_start_out_o && !general_trip_out_o ##1 start_q == 3'h0;
	endproperty
	a_block_clears: assert property (p_block_clears) else $error("outputs not cleared by block"); // R11

	// General start tracks the phase starts
	property p_gen_or;
		@(posedge clk_i) disable iff (rst_i)
		general_start_out_o == (|start_q);
	endproperty
	a_gen_or: assert property (p_gen_or) else $error("general start not OR of phases"); // R9

	// Trip only with an operating phase behind it
	property p_trip_cause;
		@(posedge clk_i) disable iff (rst_i)
		general_trip_out_o |-> general_start_out_o && $past(|ph_operate, 2);
	endproperty
	a_trip_cause: assert property (p_trip_cause) else $error("trip without operate"); // R10

	// Controlled mode never starts at high voltage
	sequence s_ctl_high;
		mode == VDOC_CONTROLLED && volt[0] >= 16'(u_low) && volt[1] >= 16'(u_low)
			&& volt[2] >= 16'(u_low);
	endsequence
	property p_ctl_high;
		@(posedge clk_i) disable iff (rst_i)
		s_ctl_high [*3] |-> !general_start_out_o;
	endproperty
	a_ctl_high: assert property (p_ctl_high) else $error("controlled start above knee"); // R7

	// Phase one trips no earlier than the delay
	property p_delay_min;
		@(posedge clk_i) disable iff (rst_i)
		$rose(ph_trip[0]) |-> $past(chk_ticks) >= $past(delay_ms);
	endproperty
	a_delay_min: assert property (p_delay_min) else $error("phase trip before delay"); // R8

	// Leaving the region drops the phase start
	property p_leave_clears;
		@(posedge clk_i) disable iff (rst_i)
		!ph_operate[0] |=> !ph_start[0] ##1 !start_q[0];
	endproperty
	a_leave_clears: assert property (p_leave_clears) else $error("start kept outside region"); // R14

	// Trip holds while a tripped phase stays operated
	property p_trip_hold;
		@(posedge clk_i) disable iff (rst_i)
		(ph_trip[0] && ph_operate[0] && !blocked) [*2] |=> general_trip_out_o;
	endproperty
	a_trip_hold: assert property (p_trip_hold) else $error("trip dropped while operated"); // R15

	// Restrained low voltage below reduced threshold never operates
	property p_low_knee;
		@(posedge clk_i) disable iff (rst_i)
		(mode == VDOC_RESTRAINED && volt[0] <= 16'(u_low) && ik_factor <= PCT_SCALE
			&& 40'(cur[0]) * 40'(PCT_SCALE) <= 40'(pickup) * 40'(ik_factor)) |-> !ph_operate[0];
	endproperty
	a_low_knee: assert property (p_low_knee) else $error("operate under reduced threshold"); // R5

	// Interrupt level follows sticky bits; a mask write takes effect one cycle later
	property p_irq;
		@(posedge clk_i) disable iff (rst_i)
		irq_o == (|(irq_status & $past(irq_mask)));
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt missing");

	// Ack is a single cycle pulse
	property p_ack;
		@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack: assert property (p_ack) else $error("ack longer than one cycle");

endmodule : vdoc_top

/* vdoc_top_tb.sv */
// Self-checking bench of the voltage dependent overcurrent block
`timescale 1ns/1ps
module vdoc_top_tb;
	import vdoc_pkg::*;
	localparam logic [7:0]  RADR [8] = '{REG_CTRL, REG_U_LOW, REG_U_HIGH, REG_IK_FACTOR,
		REG_PICKUP, REG_DELAY, REG_IRQ_MASK, 8'h24};
	localparam logic [31:0] RVAL [8] = '{32'h0, 32'h1e, 32'h50, 32'h1e, 32'hc8, 32'h64, 32'h0, 32'h0};
	// Restrained cases on knees 30/80, factor 30, pickup 200
	localparam logic [15:0] RC [8] = '{16'hc9, 16'hc8, 16'hc9, 16'h3d, 16'h3c, 16'h3d, 16'h8c, 16'h78};
	localparam logic [15:0] RV [8] = '{16'h5a, 16'h5a, 16'h50, 16'h14, 16'h14, 16'h1e, 16'h37, 16'h37};
	localparam logic [7:0]  RE = 8'b01101101;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [15:0] cur_cmd [3] = '{default: 16'h0};
	logic [15:0] volt_cmd [3] = '{default: 16'h0};
	logic        ublk_cmd = 1'b0;
	logic        vtblk_cmd = 1'b0;
	logic [15:0] cur [3];
	logic [15:0] volt [3];
	logic [15:0] ln [3];
	logic        ublk, vtblk, st1, st2, st3, gst, gtr, irq, ack;
	logic [31:0] rd, q;
	int          n_errors = 0;
	int          samples_checked = 0;
	int          cyc_cnt = 0;
	int          t;

	always #5 clk = ~clk;

	vdoc_meas_model u_meas (.clk_i(clk), .cur_cmd_i(cur_cmd), .volt_cmd_i(volt_cmd), .ublk_cmd_i(ublk_cmd),
		.vtblk_cmd_i(vtblk_cmd), .cur_o(cur), .volt_o(volt), .line_o(ln), .ublk_o(ublk), .vtblk_o(vtblk));

	// Short millisecond tick keeps the delay tests brief
	vdoc_top #(.TICK_CYCLES(10)) u_dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rd), .wb_ack_o(ack),
		.phase1_cur_i(cur[0]), .phase2_cur_i(cur[1]), .phase3_cur_i(cur[2]), .phase1_volt_i(volt[0]),
		.phase2_volt_i(volt[1]), .phase3_volt_i(volt[2]), .line12_volt_i(ln[0]), .line23_volt_i(ln[1]),
		.line31_volt_i(ln[2]), .user_block_in_i(ublk), .vt_supervision_block_in_i(vtblk),
		.phase1_start_out_o(st1), .phase2_start_out_o(st2), .phase3_start_out_o(st3),
		.general_start_out_o(gst), .general_trip_out_o(gtr), .irq_o(irq));

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic chk_bit(input string nm, input logic e, input logic g);
		samples_checked++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %s expected %b seen %b", nm, e, g);
		end
	endtask : chk_bit

	// Classic single cycle; ack and read data taken at the edge that shows ack
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do @(posedge clk); while (ack !== 1'b1);
		q = rd;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask : wb

	task automatic drive(input logic [15:0] c1, c2, c3, v1, v2, v3);
		@(posedge clk);
		cur_cmd <= '{c1, c2, c3};
		volt_cmd <= '{v1, v2, v3};
	endtask : drive

	// Model, then two design edges; five cycles leaves margin
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
	endtask : settle

	task automatic probe(input logic [15:0] c, v1, v2, v3, input logic e);
		drive(c, 16'h0, 16'h0, v1, v2, v3);
		settle(5);
		chk_bit("phase1_start", e, st1);
		chk_bit("general_start", e, gst);
		drive(16'h0, 16'h0, 16'h0, v1, v2, v3);
		settle(5);
	endtask : probe

	task automatic end_sim;
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : end_sim

	// Hang guard, well above the expected run length
	always @(posedge clk) begin
		cyc_cnt++;
		if (cyc_cnt == 20000) begin
			n_errors++;
			end_sim();
		end
	end

	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			wb(1'b0, RADR[i], 32'h0);
			chk("reset_value", RVAL[i], q);
		end
		wb(1'b1, REG_STATUS, 32'hff);
		wb(1'b0, REG_STATUS, 32'h0);
		chk("status_read_only", 32'h0, q);
		wb(1'b1, REG_DELAY, 32'h5);
		wb(1'b1, REG_IRQ_MASK, 32'h1f);
		probe(16'h3e8, 16'ha, 16'ha, 16'ha, 1'b0);
		$display("test registers done");
		wb(1'b1, REG_CTRL, 32'h1);
		for (int i = 0; i < 8; i++) begin
			probe(RC[i], RV[i], RV[i], RV[i], RE[i]);
		end
		probe(16'h96, 16'h5a, 16'h14, 16'h14, 1'b0);
		wb(1'b1, REG_CTRL, 32'h5);
		probe(16'h96, 16'h5a, 16'h14, 16'h14, 1'b1);
		wb(1'b1, REG_CTRL, 32'h3);
		probe(16'hc9, 16'h14, 16'h14, 16'h14, 1'b1);
		probe(16'hc8, 16'h14, 16'h14, 16'h14, 1'b0);
		probe(16'h3e8, 16'h1e, 16'h1e, 16'h1e, 1'b0);
		$display("test characteristics done");
		wb(1'b1, REG_CTRL, 32'h1);
		drive(16'h0, 16'h12c, 16'h0, 16'h5a, 16'h5a, 16'h5a);
		settle(5);
		chk("phase_starts_2", 32'h2, {st3, st2, st1});
		chk_bit("general_start_2", 1'b1, gst);
		drive(16'h0, 16'h0, 16'h12c, 16'h5a, 16'h5a, 16'h5a);
		settle(5);
		chk("phase_starts_3", 32'h4, {st3, st2, st1});
		drive(16'h0, 16'h0, 16'h0, 16'h5a, 16'h5a, 16'h5a);
		settle(5);
		wb(1'b1, REG_IRQ_STATUS, 32'h1f);
		$display("test phase outputs done");
		drive(16'h12c, 16'h0, 16'h0, 16'h5a, 16'h5a, 16'h5a);
		t = 0;
		while (gtr !== 1'b1 && t < 100) begin
			@(posedge clk);
			t++;
		end
		chk_bit("trip_delay_window", 1'b1, t >= 38 && t <= 58);
		settle(20);
		chk_bit("trip_held", 1'b1, gtr);
		chk_bit("irq_level", 1'b1, irq);
		wb(1'b0, REG_IRQ_STATUS, 32'h0);
		chk("irq_status", 32'h19, q);
		wb(1'b0, REG_STATUS, 32'h0);
		chk("status_tripped", 32'hc9, q);
		drive(16'h0, 16'h0, 16'h0, 16'h5a, 16'h5a, 16'h5a);
		settle(4);
		chk_bit("trip_dropped", 1'b0, gtr);
		chk_bit("phase1_dropped", 1'b0, st1);
		wb(1'b1, REG_IRQ_STATUS, 32'h1f);
		settle(2);
		chk_bit("irq_cleared", 1'b0, irq);
		wb(1'b1, REG_IRQ_MASK, 32'h0);
		drive(16'h0, 16'h12c, 16'h0, 16'h5a, 16'h5a, 16'h5a);
		settle(5);
		chk_bit("irq_masked", 1'b0, irq);
		wb(1'b0, REG_IRQ_STATUS, 32'h0);
		chk("irq_status_masked", 32'h0a, q);
		wb(1'b1, REG_IRQ_MASK, 32'h1f);
		wb(1'b1, REG_IRQ_STATUS, 32'h1f);
		$display("test trip and interrupt done");
		drive(16'h12c, 16'h0, 16'h0, 16'h5a, 16'h5a, 16'h5a);
		settle(30);
		drive(16'h0, 16'h0, 16'h0, 16'h5a, 16'h5a, 16'h5a);
		settle(5);
		drive(16'h12c, 16'h0, 16'h0, 16'h5a, 16'h5a, 16'h5a);
		settle(35);
		chk_bit("timer_restarted", 1'b0, gtr);
		drive(16'h0, 16'h0, 16'h0, 16'h5a, 16'h5a, 16'h5a);
		settle(5);
		$display("test timer restart done");
		for (int b = 0; b < 2; b++) begin
			drive(16'h12c, 16'h0, 16'h0, 16'h5a, 16'h5a, 16'h5a);
			settle(5);
			chk_bit("start_before_block", 1'b1, gst);
			@(posedge clk);
			ublk_cmd <= (b == 0);
			vtblk_cmd <= (b == 1);
			settle(4);
			chk("blocked_outputs", 32'h0, {gtr, gst, st3, st2, st1});
			settle(60);
			chk_bit("blocked_trip", 1'b0, gtr);
			@(posedge clk);
			ublk_cmd <= 1'b0;
			vtblk_cmd <= 1'b0;
			settle(5);
			chk_bit("start_after_block", 1'b1, st1);
			drive(16'h0, 16'h0, 16'h0, 16'h5a, 16'h5a, 16'h5a);
			settle(5);
		end
		$display("test blocking done");
		end_sim();
	end
endmodule : vdoc_top_tb
